/* include/tdm_switch_defs.svh */
// constants for the tdm switch slot scheduler: timing counts, reset values, codes
// assumes: included by every design file of the block, no other dependency
`ifndef TDM_SWITCH_DEFS_SVH
`define TDM_SWITCH_DEFS_SVH

`define LINES          8
`define FREE_BIT       3
`define FIRST_FREE     4'd8
`define LATE_ARM       4'd12
`define LAST_CYC       4'd15
`define WR_CYC         4'd0
`define LAST_SLOT      5'd31
`define EXEC_CYC       3'd5
`define EXEC_LAST      3'd1
`define SAMPLE_PH      1'b1
`define SAME_FRAME_GAP 6'd2
`define BUF_LAST       2'd3
`define IDLE_BYTE      8'hff
`define DISC_WORD      9'h1ff
`define CH0_BAD_TOP    2'b01
`define BUS_IDLE       11'h600

`endif

/* include/tdm_switch_pkg.sv */
// types shared by the tdm switch slot scheduler and its helper modules
// assumes: compiled before any design file
package tdm_switch_pkg;

    typedef enum logic [2:0] {
        CMD_NONE       = 3'b000,
        CMD_CONNECT    = 3'b001,
        CMD_DISCONNECT = 3'b010,
        CMD_INSERT     = 3'b011,
        CMD_EXTRACT    = 3'b100,
        CMD_MAP_READ   = 3'b101,
        CMD_CH0_FAST   = 3'b110
    } cmd_e;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_WAIT = 2'b01,
        EX_RUN  = 2'b10
    } exec_e;

    typedef struct packed {
        logic [4:0] slot;
        logic [3:0] mcycle;
    } slot_pos_s;

    typedef struct packed {
        logic       rd_n;
        logic       wr_n;
        logic       cmd_data;
        logic [7:0] data;
    } upbus_s;

    typedef struct packed {
        cmd_e            cmd;
        logic            match;
        logic [3:0][7:0] b;
    } instr_s;

    typedef logic [8:0] cm_word_t;

endpackage

/* rtl/strobe_sync.sv */
// synchroniser for the microprocessor strobes, command/data flag and data bus
// assumes: strobes unrelated to mclk; data and flag stable while a strobe is low
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defs.svh"

module strobe_sync (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire tdm_switch_pkg::upbus_s pins,
    output tdm_switch_pkg::upbus_s      bus,
    output logic                        rd_rise,
    output logic                        wr_rise
);
    import tdm_switch_pkg::*;

    upbus_s meta;
    upbus_s stab;

    // edges come from the second and third stages only, never from meta [RL10]
    always_comb begin
        rd_rise = stab.rd_n & ~bus.rd_n;
        wr_rise = stab.wr_n & ~bus.wr_n;
    end

    // data rides the same stages; it is only used while the strobe is still low in bus
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= `BUS_IDLE;
            stab <= `BUS_IDLE;
            bus  <= `BUS_IDLE;
        end else begin
            meta <= pins;
            stab <= meta;
            bus  <= stab;
        end
    end

endmodule
`default_nettype wire

/* rtl/pcm_serdes.sv */
// serial to parallel and back for the eight pcm lines, one byte per slot per line
// assumes: streams synchronous to mclk, two mclk periods per pcm bit, msb first
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defs.svh"

module pcm_serdes (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire tdm_switch_pkg::slot_pos_s pos,
    input  wire logic [7:0]                pcm_in,
    input  wire logic [7:0][7:0]           load_bytes,
    output logic [7:0][7:0]                in_bytes,
    output logic [7:0]                     pcm_out
);
    import tdm_switch_pkg::*;

    logic [7:0][7:0] in_sh;
    logic [7:0][7:0] next_in_sh;
    logic [7:0][7:0] next_in_bytes;
    logic [7:0][7:0] out_sh;
    logic [7:0][7:0] next_out_sh;

    always_comb begin
        next_in_sh    = in_sh;
        next_in_bytes = in_bytes;
        next_out_sh   = out_sh;
        for (int l = 0; l < `LINES; l++) begin
            // late half of the bit: lines skewed by up to almost a bit still land [RL15] [RL11]
            if (pos.mcycle[0] == `SAMPLE_PH) begin
                next_in_sh[l] = {in_sh[l][6:0], pcm_in[l]};
            end
            if (pos.mcycle == `LAST_CYC) begin
                next_in_bytes[l] = next_in_sh[l];
                next_out_sh[l]   = load_bytes[l];
            // outputs change at bit start, so a looped-back line is sampled mid-bit [RL16]
            end else if (pos.mcycle[0] == `SAMPLE_PH) begin
                next_out_sh[l] = {out_sh[l][6:0], 1'b1};
            end
        end
    end

    always_comb begin
        for (int l = 0; l < `LINES; l++) begin
            pcm_out[l] = out_sh[l][7];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_sh    <= '0;
            in_bytes <= '0;
            out_sh   <= '1;
        end else begin
            in_sh    <= next_in_sh;
            in_bytes <= next_in_bytes;
            out_sh   <= next_out_sh;
        end
    end

endmodule
`default_nettype wire

/* rtl/tdm_switch_slot_scheduler.sv */
// slot timing, speech and connection memories and instruction engine of the switch
// assumes: pcm lines and sync synchronous to mclk; strobes may be asynchronous
//
// Operation
// RL1 - each slot is sixteen clock periods, one machine cycle each
// RL2 - cycles 0..7 serve speech memory, cycles 8..15 run host instructions
// RL3 - an instruction completes five free cycles after its command byte
// RL4 - unfinished work pauses across the internal block, adding eight cycles
// RL5 - fast channel-0 extraction holds other instructions until done or frame start
// RL6 - output uses this frame's byte when out channel >= in channel + 2
// RL7 - host spaces channel-0 reads: 3 periods first-second, 13 second-first
// RL8 - in a multi-chip matrix host aligns strobes 20 ns after clock fall
// RL9 - unaligned strobes may corrupt only the first bit of the first byte
// RL10 - single chip accepts strobes unrelated to the clock
// RL11 - the system supplies pcm streams synchronous to the clock
// RL12 - only the chip whose straps equal the matrix address executes
// RL13 - selected non-matching chip disconnects on connect/insert, else ignores (map read still loads its readback byte and flag)
// RL14 - only the matching chip drives the data bus on reads
// RL15 - pcm inputs tolerate almost one bit of mutual skew
// RL16 - pcm outputs may be looped straight back into inputs
// RL17 - frame sync rising edge marks bit 0 of channel 0
// RL18 - connection word: nine bits, top bit selects route or inserted byte
// RL19 - slot and cycle counters restart at every frame sync edge
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defs.svh"

module tdm_switch_slot_scheduler (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       sync_n,
    input  wire logic [7:0] pcm_in,
    output logic [7:0]      pcm_out,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       cmd_data,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    input  wire logic       shared_chip_select,
    input  wire logic       column_select_n,
    input  wire logic       matrix_addr_hi,
    input  wire logic       matrix_addr_lo,
    input  wire logic       strap_row_sel,
    input  wire logic       strap_col_sel
);
    import tdm_switch_pkg::*;

    logic            rst_meta;
    logic            rst_n;
    slot_pos_s       pos;
    slot_pos_s       next_pos;
    logic            sync_prev;
    logic            frame_par;
    logic            next_frame_par;
    logic            frame_start;
    logic [7:0][7:0] in_bytes;
    logic [7:0][7:0] out_stage;
    logic [7:0][7:0] next_out_stage;
    logic [4:0]      out_slot;
    logic            out_par;
    upbus_s          bus;
    logic            rd_rise;
    logic            wr_rise;
    logic [7:0]      speech_memory [0:511];
    cm_word_t        connection_memory [0:255];
    logic [255:0]    cm_init;
    logic            sm_we;
    logic            sm_wbank;
    logic [4:0]      sm_wch;
    logic            cm_we;
    logic [7:0]      cm_waddr;
    cm_word_t        cm_wdata;
    cm_word_t        map_word;
    exec_e           state;
    exec_e           next_state;
    instr_s          instr;
    instr_s          next_instr;
    logic [2:0]      exec_cnt;
    logic [2:0]      next_exec_cnt;
    logic [1:0]      buf_idx;
    logic [1:0]      next_buf_idx;
    logic [3:0][7:0] data_buf;
    logic [3:0][7:0] next_data_buf;
    logic            do_exec;
    logic            selected;
    logic            matched;
    logic [7:0]      readback_byte_reg;
    logic [7:0]      next_readback_byte;
    logic            readback_flag_reg;
    logic            next_readback_flag;
    logic [7:0]      ch0_valid;
    logic [7:0]      next_ch0_valid;
    logic [7:0]      ch0_set;
    logic [7:0][7:0] ch0_buf;
    logic [7:0][7:0] next_ch0_buf;
    logic            ch0_active;
    logic [2:0]      ch0_head;
    logic            ch0_pop;
    logic            rd_drive;
    logic [7:0]      next_data_out;

    // external reset released through two flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [7:0] cm_addr(input logic [7:0] line_b, input logic [7:0] ch_b);
        return {line_b[2:0], ch_b[4:0]};
    endfunction

    // write-through for the byte being stored in this very cycle
    function automatic logic [7:0] sm_read(input logic bank, input logic [2:0] line,
                                           input logic [4:0] ch);
        if (sm_we && bank == sm_wbank && ch == sm_wch) begin
            return in_bytes[line];
        end
        return speech_memory[{bank, line, ch}];
    endfunction

    // a word never written reads as idle, so lines stay quiet until programmed
    function automatic logic [7:0] out_byte(input logic [2:0] oline, input logic [4:0] och,
                                            input logic opar);
        cm_word_t w;
        logic     bank;
        w    = connection_memory[{oline, och}];
        bank = ({1'b0, och} >= {1'b0, w[4:0]} + `SAME_FRAME_GAP) ? opar : ~opar; // [RL6]
        if (!cm_init[{oline, och}]) begin
            return `IDLE_BYTE;
        end
        if (w[8]) begin
            return w[7:0]; // [RL18]
        end
        return sm_read(bank, w[7:5], w[4:0]);
    endfunction

    function automatic logic ch0_ok(input logic [7:0] b);
        return b[7:6] != `CH0_BAD_TOP;
    endfunction

    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = '0;
        for (int i = `LINES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    always_comb begin
        frame_start    = sync_n & ~sync_prev; // [RL17]
        next_pos       = frame_start ? '0 : slot_pos_s'(pos + 9'd1); // [RL1] [RL19]
        next_frame_par = frame_par ^ frame_start;
    end

    pcm_serdes u_serdes (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .pos        (pos),
        .pcm_in     (pcm_in),
        .load_bytes (out_stage),
        .in_bytes   (in_bytes),
        .pcm_out    (pcm_out)
    );

    strobe_sync u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .pins    ({rd_n, wr_n, cmd_data, data_in}),
        .bus     (bus),
        .rd_rise (rd_rise),
        .wr_rise (wr_rise)
    );

    // internal cycles: store last slot's input bytes, then build next slot's outputs [RL2]
    always_comb begin
        sm_we          = !pos.mcycle[`FREE_BIT] && pos.mcycle == `WR_CYC;
        sm_wch         = pos.slot - 5'd1;
        sm_wbank       = (pos.slot == '0) ? ~frame_par : frame_par;
        out_slot       = pos.slot + 5'd1;
        out_par        = (pos.slot == `LAST_SLOT) ? ~frame_par : frame_par;
        next_out_stage = out_stage;
        if (!pos.mcycle[`FREE_BIT]) begin
            next_out_stage[pos.mcycle[2:0]] = out_byte(pos.mcycle[2:0], out_slot, out_par);
        end
    end

    always_comb begin
        selected      = shared_chip_select & ~column_select_n;
        matched       = (matrix_addr_hi == strap_row_sel) && (matrix_addr_lo == strap_col_sel);
        next_state    = state;
        next_instr    = instr;
        next_exec_cnt = exec_cnt;
        next_buf_idx  = buf_idx;
        next_data_buf = data_buf;
        do_exec       = 1'b0;
        if (wr_rise && selected && !bus.cmd_data) begin
            next_data_buf[buf_idx] = bus.data;
            if (buf_idx != `BUF_LAST) begin
                next_buf_idx = buf_idx + 2'd1;
            end
        end
        case (state)
            EX_IDLE: begin
                if (wr_rise && selected && bus.cmd_data) begin
                    next_instr.cmd   = cmd_e'(bus.data[2:0]);
                    next_instr.match = matched; // [RL12]
                    next_instr.b     = data_buf;
                    next_buf_idx     = '0;
                    next_state       = EX_WAIT;
                end
            end
            EX_WAIT: begin
                if (!ch0_active) begin // [RL5]
                    next_state    = EX_RUN;
                    next_exec_cnt = `EXEC_CYC;
                end
            end
            EX_RUN: begin
                // only free cycles count, so the internal block stretches the run by eight
                if (pos.mcycle[`FREE_BIT]) begin // [RL3] [RL4]
                    if (exec_cnt == `EXEC_LAST) begin
                        do_exec    = 1'b1;
                        next_state = EX_IDLE;
                    end else begin
                        next_exec_cnt = exec_cnt - 3'd1;
                    end
                end
            end
            default: next_state = EX_IDLE;
        endcase
    end

    always_comb begin
        cm_we              = 1'b0;
        cm_waddr           = cm_addr(instr.b[2], instr.b[3]);
        cm_wdata           = `DISC_WORD;
        map_word           = connection_memory[cm_addr(instr.b[0], instr.b[1])];
        next_readback_byte = readback_byte_reg;
        next_readback_flag = readback_flag_reg;
        next_ch0_buf       = ch0_buf;
        ch0_set            = '0;
        if (do_exec) begin
            case (instr.cmd)
                // losers write the disconnect on the same cycle as the winner's connect;
                // unaligned strobes can skew that by a cycle and spoil one bit [RL9] [RL13]
                CMD_CONNECT: begin
                    cm_we = 1'b1;
                    if (instr.match) begin
                        cm_wdata = {1'b0, instr.b[0][2:0], instr.b[1][4:0]}; // [RL18]
                    end
                end
                CMD_INSERT: begin
                    cm_we = 1'b1;
                    if (instr.match) begin
                        cm_wdata = {1'b1, instr.b[0][3:0], instr.b[1][3:0]};
                    end
                end
                CMD_DISCONNECT: begin
                    cm_we    = instr.match; // [RL12]
                    cm_waddr = cm_addr(instr.b[0], instr.b[1]);
                end
                CMD_EXTRACT: begin
                    if (instr.match) begin
                        next_readback_byte = out_byte(instr.b[0][2:0], instr.b[1][4:0],
                                                      frame_par);
                    end
                end
                CMD_MAP_READ: begin
                    next_readback_byte = cm_init[cm_addr(instr.b[0], instr.b[1])] ?
                                         map_word[7:0] : `IDLE_BYTE;
                    next_readback_flag = !cm_init[cm_addr(instr.b[0], instr.b[1])] |
                                         map_word[8];
                end
                CMD_CH0_FAST: begin
                    for (int l = 0; l < `LINES; l++) begin
                        next_ch0_buf[l] = sm_read(frame_par, 3'(l), '0);
                        ch0_set[l]      = instr.match && instr.b[0][l] && ch0_ok(next_ch0_buf[l]);
                    end
                end
                default: ;
            endcase
        end
    end

    // each first-register read hands out the next captured line; host paces these [RL7]
    always_comb begin
        ch0_active     = |ch0_valid;
        ch0_head       = first_set(ch0_valid);
        rd_drive       = !bus.rd_n && selected && matched; // [RL14]
        ch0_pop        = rd_rise && selected && matched && !bus.cmd_data && ch0_active;
        // a capture in the cycle of a pop or frame start still lands
        next_ch0_valid = (ch0_valid & ~(ch0_pop ? (8'h01 << ch0_head) : 8'h00)
                          & {8{~frame_start}}) | ch0_set; // [RL5]
        next_data_out  = data_out;
        if (rd_drive) begin
            if (bus.cmd_data) begin
                next_data_out = {state != EX_IDLE, ch0_active, 5'b00000, readback_flag_reg};
            end else begin
                next_data_out = ch0_active ? ch0_buf[ch0_head] : readback_byte_reg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sm_we) begin
            for (int l = 0; l < `LINES; l++) begin
                speech_memory[{sm_wbank, 3'(l), sm_wch}] <= in_bytes[l];
            end
        end
        if (cm_we) begin
            connection_memory[cm_waddr] <= cm_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos               <= '0;
            sync_prev         <= 1'b1;
            frame_par         <= 1'b0;
            out_stage         <= '1;
            cm_init           <= '0;
            state             <= EX_IDLE;
            instr             <= '0;
            exec_cnt          <= '0;
            buf_idx           <= '0;
            data_buf          <= '0;
            readback_byte_reg <= '0;
            readback_flag_reg <= 1'b0;
            ch0_valid         <= '0;
            ch0_buf           <= '0;
            data_out          <= '0;
            data_oe           <= 1'b0;
        end else begin
            pos               <= next_pos;
            sync_prev         <= sync_n;
            frame_par         <= next_frame_par;
            out_stage         <= next_out_stage;
            if (cm_we) begin
                cm_init[cm_waddr] <= 1'b1;
            end
            state             <= next_state;
            instr             <= next_instr;
            exec_cnt          <= next_exec_cnt;
            buf_idx           <= next_buf_idx;
            data_buf          <= next_data_buf;
            readback_byte_reg <= next_readback_byte;
            readback_flag_reg <= next_readback_flag;
            ch0_valid         <= next_ch0_valid;
            ch0_buf           <= next_ch0_buf;
            data_out          <= next_data_out;
            data_oe           <= rd_drive;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_armed_at(logic [3:0] c);
        state == EX_RUN && exec_cnt == `EXEC_CYC && pos.mcycle == c;
    endsequence

    sequence s_done;
        do_exec ##1 state == EX_IDLE;
    endsequence

    a_exec_latency: assert property (s_armed_at(`FIRST_FREE) |-> ##4 s_done) // [RL3]
        else $error("instruction not done after five free cycles");
    a_exec_suspend: assert property (s_armed_at(`LATE_ARM) |-> ##12 s_done) // [RL4]
        else $error("instruction not suspended across internal block");
    a_run_frozen: assert property (state == EX_RUN && !pos.mcycle[`FREE_BIT] // [RL2]
        |=> $stable(exec_cnt) && !$past(do_exec))
        else $error("instruction advanced in an internal cycle");
    a_slot_length: assert property (pos.mcycle == `LAST_CYC && !frame_start // [RL1]
        |=> pos.mcycle == '0 && pos.slot == $past(pos.slot) + 5'd1)
        else $error("slot not sixteen cycles long");
    a_frame_origin: assert property ($rose(sync_n) |=> pos == '0) // [RL17] [RL19]
        else $error("frame count not restarted on sync edge");
    a_ch0_priority: assert property (state == EX_WAIT && ch0_active |=> state == EX_WAIT) // [RL5]
        else $error("instruction started during channel-0 extraction");
    a_ch0_frame_end: assert property (frame_start && ch0_set == '0 |=> !ch0_active) // [RL5]
        else $error("channel-0 extraction outlived the frame");
    a_bus_release: assert property (data_oe |-> $past(rd_drive) && $past(matched)) // [RL14]
        else $error("data bus driven without match");
    a_nomatch_disc: assert property (do_exec && !instr.match // [RL13]
        && (instr.cmd == CMD_CONNECT || instr.cmd == CMD_INSERT)
        |-> cm_we && cm_wdata == `DISC_WORD ##1 cm_init[$past(cm_waddr)])
        else $error("non-matching chip did not disconnect");
    a_nomatch_quiet: assert property (do_exec && !instr.match // [RL12]
        && (instr.cmd == CMD_DISCONNECT || instr.cmd == CMD_EXTRACT
            || instr.cmd == CMD_CH0_FAST)
        |-> !cm_we && ch0_set == '0 ##1 $stable(readback_byte_reg))
        else $error("non-matching chip executed instruction");

endmodule
`default_nettype wire

/* sim/host_cpu.sv */
// microprocessor model: byte writes and reads on the switch host port
// assumes: mclk from the bench; strobes placed 20 ns after clock fall
`timescale 1ns/100ps
`default_nettype none
module host_cpu (
    input  wire logic       mclk,
    output logic            rd_n,
    output logic            wr_n,
    output logic            cmd_data,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    initial begin
        {rd_n, wr_n, cmd_data, data_in} = 11'h600;
    end
    // edges 20 ns after clock fall suit a matrix and a lone chip
    task automatic put(input logic cd, input logic [7:0] d);
        @(negedge mclk) #20;
        {cmd_data, data_in, wr_n} = {cd, d, 1'b0};
        repeat (4) @(negedge mclk);
        #20 wr_n = 1'b1;
        repeat (5) @(negedge mclk);
        data_in = ~d; // no stale byte once released
    endtask
    // 14 periods of recovery cover the 13-period reread gap
    task automatic get(input logic cd, output logic [7:0] d, output logic oe);
        @(negedge mclk) #20;
        {cmd_data, rd_n} = {cd, 1'b0};
        repeat (6) @(negedge mclk);
        {d, oe} = {data_out, data_oe};
        #20 rd_n = 1'b1;
        repeat (14) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

/* sim/tdm_switch_slot_scheduler_tb.sv */
// bench for the slot scheduler: connection map, match logic and idle lines
// assumes: host_cpu drives the host port; pcm lines held idle high
`timescale 1ns/100ps
`default_nettype none
module tdm_switch_slot_scheduler_tb;
    import tdm_switch_pkg::*;
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       sync_n = 1'b1;
    logic [7:0] pcm_in = 8'hff;
    logic [7:0] pcm_out, data_in, data_out;
    logic       rd_n, wr_n, cmd_data, data_oe;
    logic       sel = 1'b1;
    logic       col_n = 1'b0;
    logic       a_hi = 1'b1;
    logic       a_lo = 1'b0;
    logic       s_hi = 1'b1;
    logic       s_lo = 1'b0;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         fcnt = 0;
    int         cycles = 0;
    tdm_switch_slot_scheduler u_tdm_switch_slot_scheduler (
        .mclk, .reset_n, .sync_n, .pcm_in, .pcm_out, .rd_n, .wr_n, .cmd_data,
        .data_in, .data_out, .data_oe, .shared_chip_select(sel),
        .column_select_n(col_n), .matrix_addr_hi(a_hi), .matrix_addr_lo(a_lo),
        .strap_row_sel(s_hi), .strap_col_sel(s_lo));
    host_cpu u_host_cpu (.mclk, .rd_n, .wr_n, .cmd_data, .data_in, .data_out, .data_oe);
    always #25 mclk = ~mclk;
    always @(negedge mclk) begin
        fcnt <= (fcnt == 511) ? 0 : fcnt + 1;
        sync_n <= (fcnt != 511); // one low period per 512-period frame
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic idle_wait();
        logic [7:0] st;
        logic       oe;
        for (int i = 0; i < 20; i++) begin
            u_host_cpu.get(1'b1, st, oe);
            if (st[7] === 1'b0) return;
        end
        chk(st, 8'h00);
    endtask
    task automatic instr(input logic [7:0] b0, b1, b2, b3, input cmd_e fn, input int nb);
        logic [3:0][7:0] q;
        q = {b3, b2, b1, b0};
        for (int i = 0; i < nb; i++) u_host_cpu.put(1'b0, q[i]);
        u_host_cpu.put(1'b1, {5'h00, fn});
        if (a_hi === s_hi && col_n === 1'b0) idle_wait();
        else repeat (40) @(negedge mclk);
    endtask
    task automatic map_chk(input logic [7:0] ln, ch, exp, input logic fl);
        logic [7:0] d;
        logic       oe;
        instr(ln, ch, 0, 0, CMD_MAP_READ, 2);
        u_host_cpu.get(1'b0, d, oe);
        chk(d, exp);
        chk({7'h00, oe}, 8'h01);
        u_host_cpu.get(1'b1, d, oe);
        chk({7'h00, d[0]}, {7'h00, fl});
    endtask
    task automatic t_connect();
        map_chk(0, 1, 8'hff, 1'b1);
        instr(2, 17, 5, 20, CMD_CONNECT, 4);
        map_chk(5, 20, {3'd2, 5'd17}, 1'b0);
        col_n = 1'b1;
        instr(7, 7, 5, 20, CMD_CONNECT, 4);
        col_n = 1'b0;
        map_chk(5, 20, {3'd2, 5'd17}, 1'b0);
    endtask
    task automatic t_nonmatch();
        logic [7:0] d;
        logic       oe;
        instr(1, 2, 3, 9, CMD_CONNECT, 4);
        instr(4, 4, 6, 6, CMD_CONNECT, 4);
        a_hi = 1'b0;
        u_host_cpu.get(1'b1, d, oe);
        chk({7'h00, oe}, 8'h00);
        instr(1, 1, 6, 6, CMD_CONNECT, 4);
        instr(3, 9, 0, 0, CMD_DISCONNECT, 2);
        a_hi = 1'b1;
        map_chk(6, 6, 8'hff, 1'b1);
        map_chk(3, 9, {3'd1, 5'd2}, 1'b0);
    endtask
    task automatic t_idle_lines();
        for (int i = 0; i < 1024; i++) begin
            @(negedge mclk);
            chk(pcm_out, 8'hff);
        end
    endtask
    task automatic t_insert();
        logic [7:0] d;
        logic       oe;
        logic [7:0] s;
        logic       hit;
        instr(8'h0a, 8'h05, 0, 12, CMD_INSERT, 4);
        map_chk(0, 12, 8'ha5, 1'b1);
        instr(8'h00, 8'h0c, 0, 0, CMD_EXTRACT, 2);
        u_host_cpu.get(1'b0, d, oe);
        chk(d, 8'ha5);
        // one sample per two-period bit; only an aligned window can spell the inserted byte
        s   = 8'hff;
        hit = 1'b0;
        for (int i = 0; i < 512; i++) begin
            repeat (2) @(negedge mclk);
            s   = {s[6:0], pcm_out[0]};
            hit = hit | (s === 8'ha5);
        end
        chk({7'h00, hit}, 8'h01);
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        chk(pcm_out, 8'hff);
        chk({7'h00, data_oe}, 8'h00);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_connect();
        t_nonmatch();
        t_idle_lines();
        t_insert();
        give_verdict();
    end
endmodule
`default_nettype wire
